// file: pkg/mesf_pkg.sv
// meter event status flags: constants, register map and carrier types
`default_nettype none
package mesf_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] STATUS_IDX = 16'he503;
  localparam logic [15:0] CONFIG_IDX = 16'he504;
  localparam logic [15:0] CLEAR_IDX  = 16'he505;
  localparam logic [15:0] THRESH_IDX = 16'he506;
  localparam logic [15:0] NOLOAD_IDX = 16'he507;
  localparam logic [15:0] PHEVT_IDX  = 16'he508;

  localparam int unsigned SOFT_RESET_POS = 7;
  localparam int unsigned RESET_DONE_POS = 15;
  localparam int unsigned FLAG_W         = 26;
  localparam int unsigned CUR_W          = 24;

  localparam logic [25:0] FLAGS_RESET    = 26'h0008000;
  localparam logic [25:0] FLAGS_RESTORE  = 26'h0000000;
  localparam logic [25:0] FLAGS_RSVD     = 26'h0600000;
  localparam logic [31:0] STATUS_FIXED   = 32'h00200000;
  localparam logic [23:0] THRESH_RESET   = 24'h000000;
  localparam logic [31:0] PRDATA_RESET   = 32'h00000000;

  typedef enum logic [1:0] {
    PM_NORMAL = 2'h0,
    PM_LOW1   = 2'h1,
    PM_LOW2   = 2'h2,
    PM_SLEEP  = 2'h3
  } mesf_pmode_e;

  // event pulses from the measurement engine
  typedef struct packed {
    logic       total_noload_flag;
    logic       fund_noload_flag;
    logic       apparent_noload_flag;
    logic [2:0] miss_zc_volt;
    logic [2:0] miss_zc_cur;
    logic [2:0] zc_volt;
    logic [2:0] zc_cur;
    logic [2:0] zc_volt_rise;
    logic       sag;
    logic       overcurrent_flag;
    logic       overvoltage_flag;
    logic       current_peak_done;
    logic       voltage_peak_done;
  } mesf_evt_s;

  // phase detail levels from the measurement engine
  typedef struct packed {
    logic [2:0] total_noload_phases;
    logic [2:0] fund_noload_phases;
    logic [2:0] apparent_noload_phases;
    logic [2:0] sag_phases;
    logic [2:0] overcurrent_phases;
    logic [2:0] overvoltage_phases;
  } mesf_phase_s;

endpackage : mesf_pkg
`default_nettype wire

// file: src/mesf_status.sv
// meter event status flags register bank with apb slave
`timescale 1ns/10ps
`default_nettype none
module mesf_status
  import mesf_pkg::*;
#(
  parameter bit HAS_FUND     = 1'b1,
  parameter bit HAS_MISMATCH = 1'b1
)(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire mesf_evt_s           evt,
  input  wire mesf_phase_s         phase_in,
  input  wire logic [CUR_W-1:0]    summed_phase_current,
  input  wire logic [CUR_W-1:0]    neutral_current_sample,
  input  wire logic                mismatch_sample_valid,
  input  wire logic [31:0]         checksum_value,
  input  wire mesf_pmode_e         power_mode,
  output logic                     interrupt_out_one_n,
  output logic                     restore_busy
);

  typedef enum logic [1:0] {
    CT_RUN     = 2'b01,
    CT_RESTORE = 2'b10
  } mesf_ctl_e;

  typedef enum logic [1:0] {
    SQ_IDLE  = 2'b01,
    SQ_ARMED = 2'b10
  } mesf_seq_e;

  logic [25:0]       flags_reg;
  logic [25:0]       flags_next;
  mesf_ctl_e         ctl_reg;
  mesf_ctl_e         ctl_next;
  mesf_seq_e         seq_reg;
  mesf_seq_e         seq_next;
  logic [23:0]       thresh_reg;
  mesf_phase_s       phase_reg;
  logic [31:0]       crc_prev_reg;
  logic              crc_seen_reg;
  mesf_pmode_e       pmode_prev_reg;
  logic              done_pend_reg;
  logic [31:0]       prdata_reg;

  // bus decode
  wire logic [15:0]  word_idx   = paddr[17:2];
  wire logic         addr_upper = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0);
  wire logic         hit_status = addr_upper && (word_idx == STATUS_IDX);
  wire logic         hit_config = addr_upper && (word_idx == CONFIG_IDX);
  wire logic         hit_clear  = addr_upper && (word_idx == CLEAR_IDX);
  wire logic         hit_thresh = addr_upper && (word_idx == THRESH_IDX);
  wire logic         hit_noload = addr_upper && (word_idx == NOLOAD_IDX);
  wire logic         hit_phevt  = addr_upper && (word_idx == PHEVT_IDX);
  wire logic         hit_any    = hit_status | hit_config | hit_clear |
                                  hit_thresh | hit_noload | hit_phevt;
  wire logic         setup_ph   = psel && !penable;
  wire logic         access_ph  = psel && penable;
  wire logic         wr_acc     = access_ph && pwrite && hit_any;

  // soft reset request and wake from low power both restore defaults
  wire logic         soft_rst   = wr_acc && hit_config && pwdata[SOFT_RESET_POS];
  wire logic         wake       = (power_mode == PM_NORMAL) &&
                                  (pmode_prev_reg != PM_NORMAL);
  wire logic         run        = (ctl_reg == CT_RUN);
  wire logic         restore_go = run && (soft_rst || wake);

  // phase order: a rising a crossing must be followed by b, not c
  wire logic         seq_err    = (seq_reg == SQ_ARMED) && !evt.zc_volt_rise[1] &&
                                  evt.zc_volt_rise[2];

  // neutral current mismatch magnitude
  wire logic [23:0]  cur_diff   = (summed_phase_current >= neutral_current_sample) ?
                                  (summed_phase_current - neutral_current_sample) :
                                  (neutral_current_sample - summed_phase_current);
  wire logic         mism       = HAS_MISMATCH && mismatch_sample_valid &&
                                  (cur_diff > thresh_reg);

  wire logic         crc_chg    = crc_seen_reg && (checksum_value != crc_prev_reg);

  // hardware event sets, one per status bit except reserved bits 22:21, tied to zero
  wire logic [25:0]  set_vec    = {
    crc_chg,
    evt.voltage_peak_done,
    evt.current_peak_done,
    2'b00,
    mism,
    seq_err,
    evt.overvoltage_flag,
    evt.overcurrent_flag,
    evt.sag,
    done_pend_reg,
    evt.zc_cur,
    evt.zc_volt,
    evt.miss_zc_cur,
    evt.miss_zc_volt,
    evt.apparent_noload_flag,
    HAS_FUND && evt.fund_noload_flag,
    evt.total_noload_flag
  };

  // software clear is write one to clear; a set in the same cycle wins
  wire logic [25:0]  clr_vec    = (wr_acc && hit_clear) ? pwdata[25:0] : 26'h0;
  wire logic [25:0]  run_flags  = ((flags_reg & ~clr_vec) | set_vec) & ~FLAGS_RSVD;

  wire logic [31:0]  status_rd  = {6'h00, flags_reg[25:23], 2'b00, flags_reg[20:0]} |
                                  STATUS_FIXED;
  wire logic [31:0]  noload_rd  = {23'h0, phase_reg.apparent_noload_phases,
                                   phase_reg.fund_noload_phases,
                                   phase_reg.total_noload_phases};
  wire logic [31:0]  phevt_rd   = {17'h0, phase_reg.sag_phases, phase_reg.overvoltage_phases,
                                   3'h0, phase_reg.overcurrent_phases, 3'h0};
  wire logic [31:0]  rd_mux     = hit_status ? status_rd :
                                  hit_thresh ? {8'h00, thresh_reg} :
                                  hit_noload ? noload_rd :
                                  hit_phevt  ? phevt_rd : 32'h0;

  always_comb
  begin
    ctl_next = ctl_reg;
    unique case (ctl_reg)
      CT_RUN:     if (restore_go) ctl_next = CT_RESTORE;
      CT_RESTORE: ctl_next = CT_RUN;
      default:    ctl_next = CT_RUN;
    endcase
  end

  always_comb
  begin
    seq_next = seq_reg;
    unique case (seq_reg)
      SQ_IDLE:  if (evt.zc_volt_rise[0]) seq_next = SQ_ARMED;
      SQ_ARMED:
      begin
        if (evt.zc_volt_rise[1] || evt.zc_volt_rise[2])
          seq_next = evt.zc_volt_rise[0] ? SQ_ARMED : SQ_IDLE;
      end
      default:  seq_next = SQ_IDLE;
    endcase
    if (!run)
      seq_next = SQ_IDLE;
  end

  // restore clears every flag; reset done follows one cycle later
  assign flags_next = run ? run_flags : FLAGS_RESTORE;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_reg      <= FLAGS_RESET;
      ctl_reg        <= CT_RUN;
      seq_reg        <= SQ_IDLE;
      done_pend_reg  <= 1'b0;
      pmode_prev_reg <= PM_NORMAL;
    end
    else
    begin
      flags_reg      <= flags_next;
      ctl_reg        <= ctl_next;
      seq_reg        <= seq_next;
      done_pend_reg  <= (ctl_reg == CT_RESTORE);
      pmode_prev_reg <= power_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      thresh_reg   <= THRESH_RESET;
      phase_reg    <= '0;
      crc_prev_reg <= 32'h0;
      crc_seen_reg <= 1'b0;
    end
    else if (!run)
    begin
      thresh_reg   <= THRESH_RESET;
      phase_reg    <= '0;
      crc_seen_reg <= 1'b0;
    end
    else
    begin
      if (wr_acc && hit_thresh)
        thresh_reg <= pwdata[23:0];
      phase_reg    <= phase_in;
      crc_prev_reg <= checksum_value;
      crc_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= PRDATA_RESET;
    else if (setup_ph && !pwrite)
      prdata_reg <= rd_mux;
  end

  assign prdata              = prdata_reg;
  assign pready              = 1'b1;
  assign pslverr             = access_ph && !hit_any;
  assign interrupt_out_one_n = !flags_reg[RESET_DONE_POS];
  assign restore_busy        = !run;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_a_rise;
    run && evt.zc_volt_rise == 3'b001;
  endsequence

  sequence s_then_c;
    run && evt.zc_volt_rise == 3'b100;
  endsequence

  sequence s_quiet;
    run && evt.zc_volt_rise == 3'b000;
  endsequence

  property p_seq_err;
    s_a_rise ##1 s_then_c |=> flags_reg[19];
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("phase order error not flagged");

  property p_restore_done;
    ctl_reg == CT_RESTORE |=> flags_reg[15] == 1'b0 ##1 !interrupt_out_one_n;
  endproperty
  a_restore_done: assert property (p_restore_done) else $error("reset done late");

  property p_irq_unmasked;
    $rose(flags_reg[15]) |-> !interrupt_out_one_n;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked) else $error("irq not low");

  property p_sticky;
    run && flags_reg[9] && !clr_vec[9] && !restore_go |=> flags_reg[9] [*1] ;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_zc_cur;
    run && evt.zc_cur[2] |=> flags_reg[14];
  endproperty
  a_zc_cur: assert property (p_zc_cur) else $error("current zc not flagged");

  property p_fund_zero;
    !HAS_FUND |-> !flags_reg[1];
  endproperty
  a_fund_zero: assert property (p_fund_zero) else $error("fund no-load set");

  property p_mismatch;
    run && mism |=> flags_reg[20];
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch lost");

  property p_reserved;
    setup_ph && !pwrite && hit_status |=> prdata[21] && !prdata[22] && prdata[31:26] == 6'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits wrong");

  property p_crc;
    run && crc_chg |=> flags_reg[25];
  endproperty
  a_crc: assert property (p_crc) else $error("checksum change lost");

  // a quiet cycle between the a and c crossings keeps the order check armed
  property p_seq_gap;
    s_a_rise ##1 s_quiet ##1 s_then_c |=> flags_reg[19];
  endproperty
  a_seq_gap: assert property (p_seq_gap) else $error("gapped order error lost");

  // every event pulse except zc_volt_rise leaves its own status bit set at the next edge; fund no-load only when HAS_FUND
  property p_total_noload;
    run && evt.total_noload_flag |=> flags_reg[0];
  endproperty
  a_total_noload: assert property (p_total_noload) else $error("total no-load lost");

  property p_fund_noload;
    run && evt.fund_noload_flag |=> flags_reg[1] == HAS_FUND;
  endproperty
  a_fund_noload: assert property (p_fund_noload) else $error("fund no-load wrong");

  property p_apparent_noload;
    run && evt.apparent_noload_flag |=> flags_reg[2];
  endproperty
  a_apparent_noload: assert property (p_apparent_noload) else $error("va no-load lost");

  property p_miss_zc_volt;
    run && |evt.miss_zc_volt |=> &(flags_reg[5:3] | ~$past(evt.miss_zc_volt));
  endproperty
  a_miss_zc_volt: assert property (p_miss_zc_volt) else $error("voltage timeout lost");

  property p_miss_zc_cur;
    run && |evt.miss_zc_cur |=> &(flags_reg[8:6] | ~$past(evt.miss_zc_cur));
  endproperty
  a_miss_zc_cur: assert property (p_miss_zc_cur) else $error("current timeout lost");

  property p_zc_volt;
    run && |evt.zc_volt |=> &(flags_reg[11:9] | ~$past(evt.zc_volt));
  endproperty
  a_zc_volt: assert property (p_zc_volt) else $error("voltage zc lost");

  property p_zc_cur_all;
    run && |evt.zc_cur |=> &(flags_reg[14:12] | ~$past(evt.zc_cur));
  endproperty
  a_zc_cur_all: assert property (p_zc_cur_all) else $error("current zc lost");

  property p_sag;
    run && evt.sag |=> flags_reg[16];
  endproperty
  a_sag: assert property (p_sag) else $error("sag lost");

  property p_overcurrent;
    run && evt.overcurrent_flag |=> flags_reg[17];
  endproperty
  a_overcurrent: assert property (p_overcurrent) else $error("overcurrent lost");

  property p_overvoltage;
    run && evt.overvoltage_flag |=> flags_reg[18];
  endproperty
  a_overvoltage: assert property (p_overvoltage) else $error("overvoltage lost");

  property p_current_peak;
    run && evt.current_peak_done |=> flags_reg[23];
  endproperty
  a_current_peak: assert property (p_current_peak) else $error("current peak lost");

  property p_voltage_peak;
    run && evt.voltage_peak_done |=> flags_reg[24];
  endproperty
  a_voltage_peak: assert property (p_voltage_peak) else $error("voltage peak lost");

  // both restore triggers enter the restore cycle at once
  property p_soft_go;
    run && soft_rst |=> ctl_reg == CT_RESTORE;
  endproperty
  a_soft_go: assert property (p_soft_go) else $error("soft reset ignored");

  property p_wake_go;
    run && wake |=> ctl_reg == CT_RESTORE;
  endproperty
  a_wake_go: assert property (p_wake_go) else $error("wake restore ignored");

  property p_restore_clear;
    ctl_reg == CT_RESTORE |=> flags_reg == FLAGS_RESTORE && thresh_reg == THRESH_RESET;
  endproperty
  a_restore_clear: assert property (p_restore_clear) else $error("defaults not restored");

  property p_clear;
    run && clr_vec[0] && !set_vec[0] |=> !flags_reg[0];
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");

  property p_crc_quiet;
    run && !crc_chg && !flags_reg[25] |=> !flags_reg[25];
  endproperty
  a_crc_quiet: assert property (p_crc_quiet) else $error("checksum flag without change");

  property p_phase_capture;
    run |=> phase_reg == $past(phase_in);
  endproperty
  a_phase_capture: assert property (p_phase_capture) else $error("phase detail stale");

  property p_thresh_write;
    run && wr_acc && hit_thresh |=> thresh_reg == $past(pwdata[23:0]);
  endproperty
  a_thresh_write: assert property (p_thresh_write) else $error("threshold not written");

endmodule : mesf_status
`default_nettype wire

// file: verif/meter_event_status_flags_bench.sv
// self-checking bench for the meter event status flags register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module meter_event_status_flags_bench
  import mesf_pkg::*;
;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  mesf_evt_s         evt = '0;
  mesf_phase_s       phase_in = '0;
  logic [CUR_W-1:0]  sum_cur = '0;
  logic [CUR_W-1:0]  neut_cur = '0;
  logic              mm_valid = 1'b0;
  logic [31:0]       checksum = '0;
  mesf_pmode_e       power_mode = PM_NORMAL;
  logic              irq_n;
  logic              restore_busy;
  logic [31:0]       rd;
  logic              err;
  int                errors = 0;
  int                check_count = 0;
  localparam logic [31:0] DONE = 32'h00008000;

  mesf_status u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt(evt), .phase_in(phase_in), .summed_phase_current(sum_cur),
    .neutral_current_sample(neut_cur), .mismatch_sample_valid(mm_valid),
    .checksum_value(checksum), .power_mode(power_mode),
    .interrupt_out_one_n(irq_n), .restore_busy(restore_busy)
  );

  always #4 pclk = ~pclk;

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0000, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      errors++;
      $display("[FAIL] %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    `CHK({err, rd}, {1'b0, exp})
  endtask : rd_chk

  task automatic pulse(input mesf_evt_s e);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= '0;
  endtask : pulse

  // one event sets one bit, which stays until cleared
  task automatic evt_one(input mesf_evt_s e, input int b);
    pulse(e);
    rd_chk(STATUS_IDX, STATUS_FIXED | (32'h00000001 << b));
    rd_chk(STATUS_IDX, STATUS_FIXED | (32'h00000001 << b));
    apb(1'b1, CLEAR_IDX, 32'h00000001 << b);
    rd_chk(STATUS_IDX, STATUS_FIXED);
  endtask : evt_one

  task automatic t_reset;
    `CHK(irq_n, 1'b0)
    rd_chk(STATUS_IDX, STATUS_FIXED | DONE);
    apb(1'b1, CLEAR_IDX, DONE);
    rd_chk(STATUS_IDX, STATUS_FIXED);
    `CHK(irq_n, 1'b1)
    apb(1'b1, STATUS_IDX, 32'hffffffff);
    rd_chk(STATUS_IDX, STATUS_FIXED);
    apb(1'b0, 16'h0001, 32'h00000000);
    `CHK({err, rd}, {1'b1, 32'h00000000})
  endtask : t_reset

  task automatic t_events;
    mesf_evt_s e;
    e = '0; e.total_noload_flag = 1'b1; evt_one(e, 0);
    e = '0; e.fund_noload_flag = 1'b1; evt_one(e, 1);
    e = '0; e.apparent_noload_flag = 1'b1; evt_one(e, 2);
    for (int i = 0; i < 3; i++)
    begin
      e = '0; e.miss_zc_volt[i] = 1'b1; evt_one(e, 3 + i);
      e = '0; e.miss_zc_cur[i] = 1'b1; evt_one(e, 6 + i);
      e = '0; e.zc_volt[i] = 1'b1; evt_one(e, 9 + i);
      e = '0; e.zc_cur[i] = 1'b1; evt_one(e, 12 + i);
    end
    e = '0; e.sag = 1'b1; evt_one(e, 16);
    e = '0; e.overcurrent_flag = 1'b1; evt_one(e, 17);
    e = '0; e.overvoltage_flag = 1'b1; evt_one(e, 18);
    e = '0; e.current_peak_done = 1'b1; evt_one(e, 23);
    e = '0; e.voltage_peak_done = 1'b1; evt_one(e, 24);
  endtask : t_events

  task automatic t_seq;
    mesf_evt_s e;
    e = '0;
    e.zc_volt_rise = 3'h1; pulse(e);
    e.zc_volt_rise = 3'h2; pulse(e);
    e.zc_volt_rise = 3'h4; pulse(e);
    rd_chk(STATUS_IDX, STATUS_FIXED);
    e.zc_volt_rise = 3'h1; pulse(e);
    e.zc_volt_rise = 3'h4; pulse(e);
    rd_chk(STATUS_IDX, STATUS_FIXED | 32'h00080000);
    apb(1'b1, CLEAR_IDX, 32'h00080000);
    @(posedge pclk);
    evt.zc_volt_rise <= 3'h1;
    @(posedge pclk);
    evt.zc_volt_rise <= 3'h4;
    @(posedge pclk);
    evt <= '0;
    rd_chk(STATUS_IDX, STATUS_FIXED | 32'h00080000);
    apb(1'b1, CLEAR_IDX, 32'h00080000);
  endtask : t_seq

  task automatic t_mismatch;
    apb(1'b1, THRESH_IDX, 32'h0000000a);
    rd_chk(THRESH_IDX, 32'h0000000a);
    @(posedge pclk);
    sum_cur <= 24'h000064;
    neut_cur <= 24'h00006e;
    mm_valid <= 1'b1;
    @(posedge pclk);
    mm_valid <= 1'b0;
    rd_chk(STATUS_IDX, STATUS_FIXED);
    @(posedge pclk);
    sum_cur <= 24'h00006f;
    neut_cur <= 24'h000064;
    mm_valid <= 1'b1;
    @(posedge pclk);
    mm_valid <= 1'b0;
    rd_chk(STATUS_IDX, STATUS_FIXED | 32'h00100000);
    apb(1'b1, CLEAR_IDX, 32'h00100000);
    @(posedge pclk);
    checksum <= 32'h5a5a0001;
    rd_chk(STATUS_IDX, STATUS_FIXED | 32'h02000000);
    apb(1'b1, CLEAR_IDX, 32'h02000000);
    rd_chk(STATUS_IDX, STATUS_FIXED);
  endtask : t_mismatch

  task automatic t_phase;
    @(posedge pclk);
    phase_in <= {3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6};
    rd_chk(NOLOAD_IDX, 32'h00000111);
    rd_chk(PHEVT_IDX, 32'h00003c28);
    phase_in <= '0;
  endtask : t_phase

  task automatic t_restore;
    mesf_evt_s e;
    e = '0;
    e.sag = 1'b1;
    pulse(e);
    apb(1'b1, THRESH_IDX, 32'h000000ff);
    apb(1'b1, CONFIG_IDX, 32'h00000080);
    #1;
    `CHK(restore_busy, 1'b1)
    @(posedge pclk);
    rd_chk(STATUS_IDX, STATUS_FIXED | DONE);
    `CHK(irq_n, 1'b0)
    rd_chk(THRESH_IDX, 32'h00000000);
    for (int m = 1; m < 4; m++)
    begin
      apb(1'b1, CLEAR_IDX, DONE);
      pulse(e);
      power_mode <= mesf_pmode_e'(m);
      repeat (2) @(posedge pclk);
      power_mode <= PM_NORMAL;
      repeat (2) @(posedge pclk);
      rd_chk(STATUS_IDX, STATUS_FIXED | DONE);
      `CHK(irq_n, 1'b0)
    end
  endtask : t_restore

  // hardware reset in mid-run restores defaults and flags reset done
  task automatic t_hw_reset;
    mesf_evt_s e;
    e = '0;
    e.overvoltage_flag = 1'b1;
    pulse(e);
    apb(1'b1, THRESH_IDX, 32'h00000033);
    apb(1'b1, CLEAR_IDX, DONE);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(irq_n, 1'b0)
    rd_chk(STATUS_IDX, STATUS_FIXED | DONE);
    rd_chk(THRESH_IDX, 32'h00000000);
  endtask : t_hw_reset

  task automatic finish_test;
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_seq();
    t_mismatch();
    t_phase();
    t_restore();
    t_hw_reset();
    finish_test();
  end

  initial
  begin
    #100000;
    errors++;
    finish_test();
  end
endmodule : meter_event_status_flags_bench
`default_nettype wire
